// ==== verilog/ufc_channel.sv ====
// one uart channel with 16-byte fifos and register port
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// [R01] divisor_select_bit maps divisor bytes at 0,1
// [R02] bit 0 is lsb, first on line
// [R03] xt mode: idle flag tracks shifter only
// [R04] xt mode hides scratch register
// [R05] non-fifo mode zeroes fifo status bits
// [R06] dma select bit is ignored
// [R07] queue control mirrored at 0x20/0x21
// [R08] modem output bits are storage only
// [R09] receive fifo holds 16 bytes in fifo mode, one byte otherwise
// [R10] transmit starts once byte is written
// [R11] full transmit fifo refuses further writes
// [R12] tx interrupt when fifo empty, enabled
// [R13] first byte clears tx empty interrupt
// [R14] one char delay after first byte
// [R15] delay ends once two bytes coexisted
// [R16] trigger level reached raises rx interrupt
// [R17] full rx fifo: drop, set overrun
// [R18] timeout after 4 idle char times
// [R19] read or new byte clears timeout
// [R20] irq_identity resets to 0x01
// [R21] link_state resets to 0x60
// [R22] trigger codes give 1,4,8,14 bytes
// [R23] 16-bit divisor, reload on write
module ufc_channel
   import ufc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter logic CHANNEL_IS_SECOND = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [5:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // serial line, modem inputs and interrupt
   input wire logic rxd_i,
   input wire logic cts_i,
   input wire logic dsr_i,
   input wire logic ri_i,
   input wire logic dcd_i,
   output logic txd_o,
   output logic irq_o
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [9:0] IDLE_LIMIT = 10'(OVERSAMPLE * CHAR_BITS * TIMEOUT_CHARS);
   // -------------------------------------------------
   // synchronisers
   // -------------------------------------------------
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_a <= 5'h1f;
         sync_b <= 5'h1f;
      end else begin
         sync_a <= {dcd_i, ri_i, dsr_i, cts_i, rxd_i};
         sync_b <= sync_a;
      end
   end
   wire logic rx_s = sync_b[0];
   // -------------------------------------------------
   // register state
   // -------------------------------------------------
   logic [7:0] ien, fmt, mod, scratch_byte, qc, mdelta, mprev;
   logic [15:0] divisor;
   logic xt_mode, oe, pe, fe, bi;
   logic [7:0] next_ien, next_fmt, next_mod, next_scr, next_qc, next_mdelta;
   logic [15:0] next_divisor;
   logic next_xt_mode, next_oe, next_pe, next_fe, next_bi;
   wire logic dsel = fmt[FMT_DIV_SEL];
   wire logic fifo_on = qc[QC_ENABLE];
   wire logic wr_data = wr_i && addr_i == OFF_DATA && !dsel;
   wire logic rd_data = rd_i && addr_i == OFF_DATA && !dsel;
   wire logic rd_lst = rd_i && addr_i == OFF_LST;
   wire logic rd_mst = rd_i && addr_i == OFF_MST;
   wire logic wr_qc = wr_i && addr_i == OFF_IID;
   wire logic div_wr = wr_i && dsel && (addr_i == OFF_DATA || addr_i == OFF_IEN); // [R23]
   // -------------------------------------------------
   // fifos
   // -------------------------------------------------
   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic [PW:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
   logic [PW-1:0] tx_rp, tx_wp, rx_rp, rx_wp;
   logic tx_pop, rx_push;
   logic [7:0] rx_byte;
   logic rx_pe, rx_fe, rx_bi;
   wire logic tx_full = tx_cnt == (PW+1)'(fifo_on ? DEPTH : 1);
   wire logic rx_full = rx_cnt == (PW+1)'(fifo_on ? DEPTH : 1); // [R09]
   wire logic tx_push = wr_data && !tx_full; // [R11]
   wire logic rx_take = rx_push && !rx_full; // [R17]
   wire logic rx_pop = rd_data && rx_cnt != '0;
   wire logic tx_clr = wr_qc && (wdata_i[QC_TX_RST] || wdata_i[QC_ENABLE] != fifo_on);
   wire logic rx_clr = wr_qc && (wdata_i[QC_RX_RST] || wdata_i[QC_ENABLE] != fifo_on);
   always_comb begin
      next_tx_cnt = tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      next_rx_cnt = rx_cnt + (PW+1)'(rx_take) - (PW+1)'(rx_pop);
      if (tx_clr) next_tx_cnt = '0;
      if (rx_clr) next_rx_cnt = '0;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_cnt <= '0;
         rx_cnt <= '0;
         tx_rp <= '0;
         tx_wp <= '0;
         rx_rp <= '0;
         rx_wp <= '0;
      end else begin
         tx_cnt <= next_tx_cnt;
         rx_cnt <= next_rx_cnt;
         tx_rp <= tx_clr ? '0 : tx_rp + PW'(tx_pop);
         tx_wp <= tx_clr ? '0 : tx_wp + PW'(tx_push);
         rx_rp <= rx_clr ? '0 : rx_rp + PW'(rx_pop);
         rx_wp <= rx_clr ? '0 : rx_wp + PW'(rx_take);
      end
   end
   always_ff @(posedge clk_i) begin
      if (tx_push) tx_mem[tx_wp] <= wdata_i;
      if (rx_take) rx_mem[rx_wp] <= rx_byte;
   end
   // -------------------------------------------------
   // baud generator: one pulse per sixteenth of a bit
   // -------------------------------------------------
   logic [15:0] bcnt, next_bcnt;
   always_comb begin
      // a divisor write reloads with the new value, not the one it replaces
      next_bcnt = (bcnt <= 16'h0001) ? divisor : bcnt - 16'h0001;
      if (div_wr) next_bcnt = next_divisor; // [R23]
   end
   wire logic tick = bcnt <= 16'h0001 && !div_wr;
   // -------------------------------------------------
   // transmitter
   // -------------------------------------------------
   logic [9:0] tsh, next_tsh;
   logic [3:0] tbits, next_tbits, tsub, next_tsub;
   logic tbusy, next_tbusy;
   always_comb begin
      next_tsh = tsh;
      next_tbits = tbits;
      next_tsub = tsub;
      next_tbusy = tbusy;
      tx_pop = 1'b0;
      if (!tbusy && tx_cnt != '0 && !tx_clr) begin
         tx_pop = 1'b1; // [R10] [R11]
         next_tsh = {1'b1, tx_mem[tx_rp], 1'b0};
         next_tbits = 4'h0;
         next_tsub = 4'h0;
         next_tbusy = 1'b1;
      end else if (tbusy && tick) begin
         next_tsub = tsub + 4'h1;
         if (tsub == 4'(OVERSAMPLE - 1)) begin
            next_tsh = {1'b1, tsh[9:1]}; // [R02]
            next_tbits = tbits + 4'h1;
            if (tbits == 4'(CHAR_BITS - 1)) next_tbusy = 1'b0;
         end
      end
   end
   wire logic brk = fmt[6];
   // -------------------------------------------------
   // receiver
   // -------------------------------------------------
   logic [8:0] rsh, next_rsh;
   logic [3:0] rbits, next_rbits, rsub, next_rsub;
   logic rbusy, next_rbusy;
   always_comb begin
      next_rsh = rsh;
      next_rbits = rbits;
      next_rsub = rsub;
      next_rbusy = rbusy;
      rx_push = 1'b0;
      rx_byte = rsh[8:1];
      rx_pe = 1'b0;
      rx_fe = !rx_s;
      rx_bi = !rx_s && rsh[8:1] == 8'h00;
      if (!rbusy && !rx_s) begin
         next_rbusy = 1'b1;
         next_rsub = 4'h0;
         next_rbits = 4'h0;
      end else if (rbusy && tick) begin
         next_rsub = rsub + 4'h1;
         if (rsub == 4'(OVERSAMPLE/2 - 1)) begin
            next_rbits = rbits + 4'h1;
            if (rbits == 4'h0 && rx_s) next_rbusy = 1'b0;
            else if (rbits == 4'(CHAR_BITS - 1)) begin
               rx_push = 1'b1;
               next_rbusy = 1'b0;
            end else if (rbits != 4'h0) next_rsh = {rx_s, rsh[8:1]}; // [R02]
         end
      end
   end
   // -------------------------------------------------
   // character timer, tx delay and rx timeout
   // -------------------------------------------------
   logic [7:0] char_tk, next_char_tk;
   wire logic char_end = tick && char_tk == 8'(OVERSAMPLE * CHAR_BITS - 1);
   logic [9:0] idle_tk, next_idle_tk;
   logic tx_hold, next_tx_hold, tx_armed, next_tx_armed, holding_empty_flag_irq, next_holding_empty_flag_irq;
   wire logic tx_empty = tx_cnt == '0;
   wire logic rd_iid = rd_i && addr_i == OFF_IID;
   logic [3:0] iid_code;
   always_comb begin
      next_char_tk = char_tk;
      if (tick) next_char_tk = char_end ? 8'h00 : char_tk + 8'h01;
      // idle time runs in ticks from the last byte taken in or read out, so the timeout is four whole characters
      next_idle_tk = idle_tk;
      if (rx_take || rx_pop || rx_cnt == '0) next_idle_tk = 10'h000; // [R19]
      else if (tick && idle_tk != IDLE_LIMIT) next_idle_tk = idle_tk + 10'h001;
      next_tx_armed = tx_armed;
      next_tx_hold = tx_hold;
      if (tx_push && tx_empty) begin
         next_tx_hold = !tx_armed; // [R14]
         next_char_tk = 8'h00;
      end else if (char_end) next_tx_hold = 1'b0;
      if (tx_push && tx_cnt != '0) next_tx_armed = 1'b1; // [R15]
      else if (tx_empty && !tx_push) next_tx_armed = 1'b0;
      next_holding_empty_flag_irq = holding_empty_flag_irq;
      if (tx_push) next_holding_empty_flag_irq = 1'b0; // [R13]
      else if (rd_iid && iid_code == IID_TXEMPTY) next_holding_empty_flag_irq = 1'b0;
      if (next_tx_cnt == '0 && !tx_push && !next_tx_hold && (tx_pop || tx_hold || tx_clr))
         next_holding_empty_flag_irq = 1'b1; // [R12]
   end
   logic [7:0] trig;
   always_comb begin
      unique case (qc[7:QC_TRIG_LO]) // [R22]
         2'b00: trig = TRIG_1;
         2'b01: trig = TRIG_4;
         2'b10: trig = TRIG_8;
         2'b11: trig = TRIG_14;
      endcase
      iid_code = IID_NONE;
      if (ien[IEN_LINE] && (oe || pe || fe || bi)) iid_code = IID_LINE;
      else if (ien[IEN_RX] && 8'(rx_cnt) >= (fifo_on ? trig : 8'h01))
         iid_code = IID_RXDATA; // [R16]
      else if (ien[IEN_RX] && fifo_on && idle_tk == IDLE_LIMIT)
         iid_code = IID_TIMEOUT; // [R18]
      else if (ien[IEN_TX] && holding_empty_flag_irq) iid_code = IID_TXEMPTY; // [R12]
      else if (ien[IEN_MODEM] && mdelta[3:0] != 4'h0) iid_code = IID_MODEM;
   end
   // -------------------------------------------------
   // register writes and status flags
   // -------------------------------------------------
   always_comb begin
      next_ien = ien;
      next_fmt = fmt;
      next_mod = mod;
      next_scr = scratch_byte;
      next_qc = qc;
      next_divisor = divisor;
      next_xt_mode = xt_mode;
      if (wr_i) begin
         unique case (addr_i)
            OFF_DATA: if (dsel) next_divisor[7:0] = wdata_i; // [R01]
            OFF_IEN: begin
               if (dsel) next_divisor[15:8] = wdata_i; // [R01] [R23]
               else next_ien = {4'h0, wdata_i[3:0]};
            end
            OFF_IID: next_qc = {wdata_i[7:6], 6'h00} | {7'h00, wdata_i[0]}; // [R06]
            OFF_FMT: next_fmt = wdata_i;
            OFF_MOD: next_mod = {3'h0, wdata_i[4:0]}; // [R08]
            OFF_SCR: if (!xt_mode) next_scr = wdata_i; // [R04]
            OFF_MODE: next_xt_mode = wdata_i[0];
            default: ;
         endcase
      end
      // line errors: a new event wins over a read clearing them
      next_oe = (oe && !rd_lst) || (rx_push && rx_full); // [R17]
      next_pe = (pe && !rd_lst) || (rx_take && rx_pe);
      next_fe = (fe && !rd_lst) || (rx_take && rx_fe);
      next_bi = (bi && !rd_lst) || (rx_take && rx_bi);
      next_mdelta = 8'h00;
      next_mdelta[0] = (mdelta[0] && !rd_mst) || (sync_b[1] != mprev[0]);
      next_mdelta[1] = (mdelta[1] && !rd_mst) || (sync_b[2] != mprev[1]);
      next_mdelta[2] = (mdelta[2] && !rd_mst) || (sync_b[3] && !mprev[2]);
      next_mdelta[3] = (mdelta[3] && !rd_mst) || (sync_b[4] != mprev[3]);
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ien <= 8'h00;
         fmt <= 8'h00;
         mod <= 8'h00;
         scratch_byte <= 8'h00;
         qc <= 8'h00;
         divisor <= DIV_RESET;
         xt_mode <= 1'b0;
         {oe, pe, fe, bi} <= 4'h0;
         mdelta <= 8'h00;
         mprev <= 8'h0f;
         bcnt <= DIV_RESET;
         tsh <= 10'h3ff;
         tbits <= 4'h0;
         tsub <= 4'h0;
         tbusy <= 1'b0;
         rsh <= 9'h000;
         rbits <= 4'h0;
         rsub <= 4'h0;
         rbusy <= 1'b0;
         char_tk <= 8'h00;
         idle_tk <= 10'h000;
         tx_hold <= 1'b0;
         tx_armed <= 1'b0;
         holding_empty_flag_irq <= 1'b1;
      end else begin
         ien <= next_ien;
         fmt <= next_fmt;
         mod <= next_mod;
         scratch_byte <= next_scr;
         qc <= next_qc;
         divisor <= next_divisor;
         xt_mode <= next_xt_mode;
         {oe, pe, fe, bi} <= {next_oe, next_pe, next_fe, next_bi};
         mdelta <= next_mdelta;
         mprev <= {4'h0, sync_b[4:1]};
         bcnt <= next_bcnt;
         tsh <= next_tsh;
         tbits <= next_tbits;
         tsub <= next_tsub;
         tbusy <= next_tbusy;
         rsh <= next_rsh;
         rbits <= next_rbits;
         rsub <= next_rsub;
         rbusy <= next_rbusy;
         char_tk <= next_char_tk;
         idle_tk <= next_idle_tk;
         tx_hold <= next_tx_hold;
         tx_armed <= next_tx_armed;
         holding_empty_flag_irq <= next_holding_empty_flag_irq;
      end
   end
   // -------------------------------------------------
   // read path, one cycle late
   // -------------------------------------------------
   logic [7:0] lst, iid, next_rdata;
   always_comb begin
      lst = {fifo_on && (pe || fe || bi), // [R05]
             !tbusy && (tx_empty || xt_mode), // [R03]
             tx_empty, bi, fe, pe, oe, rx_cnt != '0}; // [R21]
      iid = {fifo_on, fifo_on, 2'b00, fifo_on ? iid_code : {1'b0, iid_code[2:0]}}; // [R05] [R20]
      next_rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            OFF_DATA: next_rdata = dsel ? divisor[7:0] : rx_mem[rx_rp]; // [R01]
            OFF_IEN: next_rdata = dsel ? divisor[15:8] : ien;
            OFF_IID: next_rdata = iid;
            OFF_FMT: next_rdata = fmt;
            OFF_MOD: next_rdata = mod;
            OFF_LST: next_rdata = lst;
            OFF_MST: next_rdata = {~sync_b[4:1], mdelta[3:0]};
            OFF_SCR: next_rdata = xt_mode ? 8'h00 : scratch_byte; // [R04]
            OFF_MODE: next_rdata = {7'h00, xt_mode};
            OFF_SHADOW1: next_rdata = CHANNEL_IS_SECOND ? 8'h00 : qc; // [R07]
            OFF_SHADOW2: next_rdata = CHANNEL_IS_SECOND ? qc : 8'h00; // [R07]
            default: next_rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         txd_o <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         rdata_o <= next_rdata;
         txd_o <= (tbusy ? tsh[0] : 1'b1) && !brk;
         irq_o <= iid_code != IID_NONE;
      end
   end
   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   AST_TX_REFUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
      tx_full && !tx_pop && !tx_clr |=> tx_cnt == $past(tx_cnt))
      else $error("write into full tx fifo accepted");
   AST_RX_CAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R09]
      rx_cnt <= (PW+1)'(DEPTH)) else $error("rx fifo beyond depth");
   AST_OVERRUN: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R17]
      rx_push && rx_full |=> oe && rx_cnt <= $past(rx_cnt))
      else $error("overrun not flagged");
   AST_HOLDING_EMPTY_FLAG_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
      tx_push |=> !holding_empty_flag_irq) else $error("tx empty irq stayed after load");
   AST_TIMEOUT_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R19]
      rx_pop |=> idle_tk == 10'h000) else $error("timeout not cleared");
   AST_NONFIFO: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R05]
      !fifo_on |-> iid[7:6] == 2'b00 && iid[3] == 1'b0 && lst[7] == 1'b0)
      else $error("fifo bits set in non-fifo mode");
   AST_SHADOW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06] [R07]
      wr_qc |=> qc[5:1] == 5'h00 && qc[7:6] == $past(wdata_i[7:6]))
      else $error("queue control mirror wrong");
   AST_DIV_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R23]
      div_wr |=> bcnt == $past(next_divisor)) else $error("bit clock not reloaded");
   AST_TX_START: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
      tx_push && !tbusy && !tx_clr |=> ##1 tbusy) else $error("transmit did not start");
   COV_TX_FULL: cover property (@(posedge clk_i) disable iff (!rst_n_i) tx_full && wr_data);
   COV_OVERRUN: cover property (@(posedge clk_i) disable iff (!rst_n_i) rx_push && rx_full);
   COV_TIMEOUT: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      iid_code == IID_TIMEOUT);
endmodule : ufc_channel

// ==== verilog/ufc_pkg.sv ====
// package: register map, field positions and reset values of the uart channel
package ufc_pkg;
   // -------------------------------------------------
   // register offsets
   // -------------------------------------------------
   localparam logic [5:0] OFF_DATA = 6'h00;
   localparam logic [5:0] OFF_IEN = 6'h01;
   localparam logic [5:0] OFF_IID = 6'h02;
   localparam logic [5:0] OFF_FMT = 6'h03;
   localparam logic [5:0] OFF_MOD = 6'h04;
   localparam logic [5:0] OFF_LST = 6'h05;
   localparam logic [5:0] OFF_MST = 6'h06;
   localparam logic [5:0] OFF_SCR = 6'h07;
   localparam logic [5:0] OFF_SHADOW1 = 6'h20;
   localparam logic [5:0] OFF_SHADOW2 = 6'h21;
   localparam logic [5:0] OFF_MODE = 6'h08;
   // -------------------------------------------------
   // field positions
   // -------------------------------------------------
   localparam int FMT_DIV_SEL = 7;
   localparam int QC_ENABLE = 0;
   localparam int QC_RX_RST = 1;
   localparam int QC_TX_RST = 2;
   localparam int QC_TRIG_LO = 6;
   localparam int IEN_RX = 0;
   localparam int IEN_TX = 1;
   localparam int IEN_LINE = 2;
   localparam int IEN_MODEM = 3;
   // -------------------------------------------------
   // reset values and codes
   // -------------------------------------------------
   localparam logic [7:0] IID_RESET = 8'h01;
   localparam logic [7:0] LST_RESET = 8'h60;
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_LINE = 4'h6;
   localparam logic [3:0] IID_RXDATA = 4'h4;
   localparam logic [3:0] IID_TIMEOUT = 4'hc;
   localparam logic [3:0] IID_TXEMPTY = 4'h2;
   localparam logic [3:0] IID_MODEM = 4'h0;
   localparam logic [15:0] DIV_RESET = 16'h0001;
   localparam int OVERSAMPLE = 16;
   localparam int TIMEOUT_CHARS = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int CHAR_BITS = 10;
   localparam logic [7:0] TRIG_1 = 8'h01;
   localparam logic [7:0] TRIG_4 = 8'h04;
   localparam logic [7:0] TRIG_8 = 8'h08;
   localparam logic [7:0] TRIG_14 = 8'h0e;
endpackage : ufc_pkg

// ==== sim/ufc_line_model.sv ====
// serial line partner: sends frames into the channel, collects frames from it
`timescale 1ns/1ps
module ufc_line_model #(
   parameter int BIT_CLKS = 16
) (
   // clock
   input wire logic clk_i,
   // serial line
   input wire logic txd_i,
   output logic rxd_o,
   // modem pins, active low, held inactive
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic ri_n_o,
   output logic dcd_n_o
);
   logic [7:0] got_q[$];
   // -------------------------------------------------
   // idle line
   // -------------------------------------------------
   initial begin
      rxd_o = 1'b1;
      cts_n_o = 1'b1;
      dsr_n_o = 1'b1;
      ri_n_o = 1'b1;
      dcd_n_o = 1'b1;
   end
   // -------------------------------------------------
   // frame sender: start, 8 data, stop
   // -------------------------------------------------
   task automatic send(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= fr[i]; // lsb first
         repeat (BIT_CLKS) @(posedge clk_i);
      end
   endtask : send
   // -------------------------------------------------
   // frame collector, samples mid-bit
   // -------------------------------------------------
   always begin
      logic [7:0] b;
      @(negedge txd_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk_i);
         b[i] = txd_i; // lsb first
      end
      repeat (BIT_CLKS) @(posedge clk_i);
      got_q.push_back(b);
   end
endmodule : ufc_line_model

// ==== sim/ufc_channel_test.sv ====
// self-checking bench for the uart channel
`timescale 1ns/1ps
module ufc_channel_test;
   import ufc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic rxd, cts_n, dsr_n, ri_n, dcd_n, txd, irq;
   logic [7:0] v;
   logic [7:0] lvl [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
   int bad_count = 0;
   int total_checks = 0;
   always #4 clk = ~clk;
   ufc_channel u_ufc_channel (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rxd_i(rxd), .cts_i(cts_n), .dsr_i(dsr_n),
      .ri_i(ri_n), .dcd_i(dcd_n), .txd_o(txd), .irq_o(irq));
   ufc_line_model u_ufc_line_model (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n),
      .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n));
   // -------------------------------------------------
   // compare and bus tasks
   // -------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask : rd_chk
   // bounded wait, then the flag is compared either way
   task automatic wait_irq(input logic exp, input int n);
      int i;
      i = 0;
      while (irq !== exp && i < n) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk({7'h00, irq}, {7'h00, exp});
   endtask : wait_irq
   task automatic wait_rx(input int n);
      int i;
      i = 0;
      while (u_ufc_line_model.got_q.size() < n && i < 4000) begin
         @(posedge clk);
         i++;
      end
   endtask : wait_rx
   task automatic results();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   // -------------------------------------------------
   // tests
   // -------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(OFF_IID, IID_RESET);
      rd_chk(OFF_LST, LST_RESET);
      $display("test reset done");
      wr_reg(OFF_FMT, 8'h80);
      wr_reg(OFF_DATA, 8'h01);
      wr_reg(OFF_IEN, 8'h5a);
      rd_chk(OFF_IEN, 8'h5a);
      rd_chk(OFF_DATA, 8'h01);
      wr_reg(OFF_IEN, 8'h00);
      wr_reg(OFF_FMT, 8'h00);
      rd_chk(OFF_IEN, 8'h00);
      $display("test divisor done");
      wr_reg(OFF_SCR, 8'ha5);
      rd_chk(OFF_SCR, 8'ha5);
      wr_reg(OFF_MODE, 8'h01);
      rd_chk(OFF_SCR, 8'h00);
      rd_chk(OFF_LST, 8'h60);
      wr_reg(OFF_MODE, 8'h00);
      wr_reg(OFF_MOD, 8'h0c);
      rd_chk(OFF_MOD, 8'h0c);
      chk({7'h00, txd}, 8'h01);
      rd_chk(OFF_IID, 8'h01);
      wr_reg(OFF_IID, 8'h09);
      rd_chk(OFF_SHADOW1, 8'h01);
      rd_chk(OFF_SHADOW2, 8'h00);
      rd_chk(OFF_IID, 8'hc1);
      $display("test registers done");
      // single byte: empty interrupt comes back only after one character time
      wr_reg(OFF_IEN, 8'h02);
      wait_irq(1'b1, 4);
      wr_reg(OFF_DATA, 8'ha5);
      wait_irq(1'b0, 4);
      repeat (100) @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
      wait_irq(1'b1, 120);
      wait_rx(1);
      chk(u_ufc_line_model.got_q.pop_front(), 8'ha5);
      repeat (20) @(posedge clk);
      // 18 loads: one to the shifter, 16 queued, the last refused
      for (int i = 0; i < 18; i++) begin
         wr_reg(OFF_DATA, 8'(i));
      end
      wait_rx(1);
      repeat (20) @(posedge clk);
      wr_reg(OFF_DATA, 8'h77);
      wait_rx(17);
      wait_irq(1'b1, 20);
      wait_rx(18);
      for (int i = 0; i < 17; i++) begin
         chk(u_ufc_line_model.got_q.pop_front(), 8'(i));
      end
      chk(u_ufc_line_model.got_q.pop_front(), 8'h77);
      repeat (200) @(posedge clk);
      chk(8'(u_ufc_line_model.got_q.size()), 8'h00);
      $display("test transmit done");
      // every trigger code, one byte short of the level stays quiet
      wr_reg(OFF_IEN, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wr_reg(OFF_IID, {c[1:0], 6'h07});
         for (int k = 1; k <= int'(lvl[c]); k++) begin
            u_ufc_line_model.send(8'(k));
            #1;
            if (k < int'(lvl[c])) begin
               chk({7'h00, irq}, 8'h00);
            end else begin
               wait_irq(1'b1, 8);
            end
         end
         rd_chk(OFF_IID, 8'hc4);
      end
      $display("test trigger done");
      wr_reg(OFF_IID, 8'hc7);
      u_ufc_line_model.send(8'h3c);
      repeat (500) @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
      wait_irq(1'b1, 300);
      rd_chk(OFF_IID, 8'hcc);
      rd_chk(OFF_DATA, 8'h3c);
      wait_irq(1'b0, 4);
      $display("test timeout done");
      // 17 bytes into a 16-deep queue: the last one overruns
      wr_reg(OFF_IID, 8'hc7);
      for (int k = 0; k < 17; k++) begin
         u_ufc_line_model.send(8'(k + 8'h50));
      end
      rd_reg(OFF_LST, v);
      chk(v & 8'h02, 8'h02);
      for (int k = 0; k < 16; k++) begin
         rd_chk(OFF_DATA, 8'(k + 8'h50));
      end
      $display("test overrun done");
      results();
   end
   initial begin
      #400000;
      bad_count++;
      results();
   end
endmodule : ufc_channel_test
